//--- src/ppi_irq_ctrl.sv
// Purpose: Per-port power-down input / interrupt output and its registers
// Assumes: Inputs synchronous to clk; one management access per cycle
// Notes:   Read data appears one cycle after the read strobe
//          Pin drive is combinational, so a masked event reaches the pad at once
//          A clearing read never drops an event of the same cycle
//
// Contract
// - After reset, pin is power-down input
// - Control bit 0 turns pin into interrupt
// - Each port owns its own pin
// - Low pin equals basic control power-down
// - Weak pull-up; external low requests power-down
// - Pin held low at reset powers down
// - Registers answer in power-down; select releases
// - All interrupt sources masked after reset
// - Control bit 1, with bit 0 set, drives masked sources out
// - Enabled event pulls pin low asynchronously
// - Status high byte shows all pending
// - Status read clears pending, pin released
// - Writing 0060h enables link, energy sources
`timescale 1ns/1ps
`default_nettype none

module ppi_irq_ctrl #(
  parameter int NPORTS = ppi_pkg::PORT_COUNT,
  parameter int NSRC   = ppi_pkg::SRC_MAX
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Management access
  input  wire ppi_pkg::ppi_req_t           regReq,
  output logic [15:0]                      rdData,
  output logic                             rdValid,
  // Interrupt sources, one pulse or level per source
  input  wire logic [NPORTS-1:0][NSRC-1:0] srcEvent,
  // Shared pins
  input  wire logic [NPORTS-1:0]           pinIn,
  output logic      [NPORTS-1:0]           pinOut,
  output logic      [NPORTS-1:0]           pinOe,
  // Port power state
  output logic      [NPORTS-1:0]           powerDown
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NPORTS != ppi_pkg::PORT_COUNT) begin : g_bad_ports
    $error("NPORTS must match the one-bit port select");
  end
  if (NSRC < 1 || NSRC > ppi_pkg::SRC_MAX) begin : g_bad_src
    $error("NSRC must lie between 1 and 8");
  end
  if (ppi_pkg::MASK_LSB + NSRC > ppi_pkg::PEND_LSB) begin : g_bad_mask
    $error("Mask field would overlap the pending field");
  end
  if (ppi_pkg::PEND_LSB + NSRC > $bits(rdData)) begin : g_bad_pend
    $error("Pending field does not fit the data word");
  end
  if (ppi_pkg::BIT_POWER_DOWN >= $bits(rdData)) begin : g_bad_pd
    $error("Power-down bit lies outside the data word");
  end
  if (ppi_pkg::BIT_PIN_AS_IRQ == ppi_pkg::BIT_IRQ_OUT_EN) begin : g_bad_ctl
    $error("Control bits must be distinct");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic regHit(input ppi_pkg::ppi_req_t req, input int p,
                                  input logic [4:0] addr);
    regHit = (req.port == 1'(p)) && (req.addr == addr);
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [NPORTS-1:0]           basicPowerDown;
  logic [NPORTS-1:0]           pinAsIrq;
  logic [NPORTS-1:0]           irqOutEnable;
  logic [NPORTS-1:0][NSRC-1:0] irqMask;
  logic [NPORTS-1:0][NSRC-1:0] irqPending;
  logic [NPORTS-1:0][NSRC-1:0] next_irqPending;
  logic [NPORTS-1:0]           irqAssert;
  logic [NPORTS-1:0]           pinPowerDown;
  logic [NPORTS-1:0]           next_powerDown;
  logic [NPORTS-1:0]           wrBasic;
  logic [NPORTS-1:0]           wrCtl;
  logic [NPORTS-1:0]           wrStat;
  logic [NPORTS-1:0]           rdStat;
  logic [15:0]                 next_rdData;

  // ----------------------------------------------------------------
  // Access decode, one write strobe per port and register, plus a read strobe for the status register
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      wrBasic[p] = regReq.wr && regHit(regReq, p, ppi_pkg::ADDR_BASIC_CTL);
      wrCtl[p]   = regReq.wr && regHit(regReq, p, ppi_pkg::ADDR_IRQ_CTL);
      wrStat[p]  = regReq.wr && regHit(regReq, p, ppi_pkg::ADDR_IRQ_STAT);
      rdStat[p]  = regReq.rd && regHit(regReq, p, ppi_pkg::ADDR_IRQ_STAT);
    end
  end

  // Sources that the mask lets through
  function automatic logic [NSRC-1:0] maskedEvents(input int p);
    maskedEvents = srcEvent[p] & irqMask[p];
  endfunction

  // ----------------------------------------------------------------
  // Basic control register, power-down bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      basicPowerDown <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (wrBasic[p]) begin
          basicPowerDown[p] <= regReq.wdata[ppi_pkg::BIT_POWER_DOWN];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt control register
  // ----------------------------------------------------------------
  // Pin starts as power-down input
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinAsIrq     <= '0;
      irqOutEnable <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (wrCtl[p]) begin
          pinAsIrq[p]     <= regReq.wdata[ppi_pkg::BIT_PIN_AS_IRQ];
          irqOutEnable[p] <= regReq.wdata[ppi_pkg::BIT_IRQ_OUT_EN];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt mask, low byte of status register
  // ----------------------------------------------------------------
  // Masks cleared at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NPORTS; p++) begin
        irqMask[p] <= ppi_pkg::RST_BYTE[NSRC-1:0];
      end
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        if (wrStat[p]) begin
          irqMask[p] <= regReq.wdata[ppi_pkg::MASK_LSB +: NSRC];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pending bits, high byte of status register
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      next_irqPending[p] = irqPending[p];
      if (rdStat[p]) begin
        next_irqPending[p] = '0;
      end
      next_irqPending[p] = next_irqPending[p] | maskedEvents(p);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqPending <= '0;
    end else begin
      irqPending <= next_irqPending;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reads served in power-down
  function automatic logic [15:0] readWord(input int p, input logic [4:0] addr);
    logic [15:0] w;
    w = ppi_pkg::RST_WORD;
    case (addr)
      ppi_pkg::ADDR_BASIC_CTL: begin
        w[ppi_pkg::BIT_POWER_DOWN] = basicPowerDown[p];
      end
      ppi_pkg::ADDR_IRQ_CTL: begin
        w[ppi_pkg::BIT_PIN_AS_IRQ] = pinAsIrq[p];
        w[ppi_pkg::BIT_IRQ_OUT_EN] = irqOutEnable[p];
      end
      ppi_pkg::ADDR_IRQ_STAT: begin
        w[ppi_pkg::PEND_LSB +: NSRC] = irqPending[p];
        w[ppi_pkg::MASK_LSB +: NSRC] = irqMask[p];
      end
      default: begin
        w = ppi_pkg::RST_WORD;
      end
    endcase
    readWord = w;
  endfunction

  // Unmapped addresses and idle cycles read as zero
  always_comb begin
    next_rdData = ppi_pkg::RST_WORD;
    if (regReq.rd) begin
      next_rdData = readWord(int'(regReq.port), regReq.addr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= ppi_pkg::RST_WORD;
    end else begin
      rdData <= next_rdData;
    end
  end

  // ----------------------------------------------------------------
  // Read strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdValid <= 1'b0;
    end else begin
      rdValid <= regReq.rd;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request, combinational from the source
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      irqAssert[p] = irqOutEnable[p]
                   & (|(irqPending[p] | maskedEvents(p)));
    end
  end

  // ----------------------------------------------------------------
  // Pin cells, one per port
  // ----------------------------------------------------------------
  // Independent pin per port
  for (genvar p = 0; p < NPORTS; p++) begin : g_pin
    ppi_pin_cell u_cell (
      .pinAsIrq     (pinAsIrq[p]),
      .irqAssert    (irqAssert[p]),
      .pinIn        (pinIn[p]),
      .pinOut       (pinOut[p]),
      .pinOe        (pinOe[p]),
      .pinPowerDown (pinPowerDown[p])
    );
  end

  // ----------------------------------------------------------------
  // Power state
  // ----------------------------------------------------------------
  // Pin low acts as power-down bit
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      next_powerDown[p] = basicPowerDown[p] | pinPowerDown[p];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powerDown <= '0;
    end else begin
      powerDown <= next_powerDown;
    end
  end

endmodule

`default_nettype wire

//--- src/ppi_pkg.sv
// Purpose: Shared constants and types for the power-down / interrupt pin logic
// Assumes: Management accesses are 16-bit words at 5-bit register addresses
// Notes:   Source bit n of the mask pairs with pending bit n + PEND_LSB
package ppi_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_BASIC_CTL = 5'h00;
  localparam logic [4:0] ADDR_IRQ_CTL   = 5'h11;
  localparam logic [4:0] ADDR_IRQ_STAT  = 5'h12;

  // ----------------------------------------------------------------
  // Field positions and sizes
  // ----------------------------------------------------------------
  localparam int BIT_POWER_DOWN = 11;
  localparam int BIT_PIN_AS_IRQ = 0;
  localparam int BIT_IRQ_OUT_EN = 1;
  localparam int MASK_LSB       = 0;
  localparam int PEND_LSB       = 8;
  localparam int SRC_MAX        = 8;
  localparam int SRC_LINK       = 5;
  localparam int SRC_ENERGY     = 6;
  localparam int PORT_COUNT     = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // Management access request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        port;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ppi_req_t;

endpackage

//--- src/ppi_pin_cell.sv
// Purpose: One shared power-down / interrupt pin, open-drain style
// Assumes: The pad pull-up makes an undriven pin read high
// Notes:   Interrupt drive is purely combinational, no clock in the path
`timescale 1ns/1ps
`default_nettype none

module ppi_pin_cell (
  // Mode and request
  input  wire logic pinAsIrq,
  input  wire logic irqAssert,
  // Pad
  input  wire logic pinIn,
  output logic      pinOut,
  output logic      pinOe,
  // Power-down request seen on the pin
  output logic      pinPowerDown
);

  // ----------------------------------------------------------------
  // Output side
  // ----------------------------------------------------------------
  // Drive low without clock
  assign pinOut = 1'b0;
  assign pinOe  = pinAsIrq & irqAssert;

  // ----------------------------------------------------------------
  // Input side
  // ----------------------------------------------------------------
  // Undriven high means run
  assign pinPowerDown = ~pinAsIrq & ~pinIn;

endmodule

`default_nettype wire

//--- testbench/ppi_irq_ctrl_sva.sv
// Purpose: Port-level checker for ppi_irq_ctrl
// Assumes: Shadow registers track management writes
// Notes:   One generate pass per port
`timescale 1ns/1ps
`default_nettype none
module ppi_irq_ctrl_sva #(
  parameter int NPORTS = 2,
  parameter int NSRC   = 8
) (
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire ppi_pkg::ppi_req_t           regReq,
  input wire logic [15:0]                 rdData,
  input wire logic                        rdValid,
  input wire logic [NPORTS-1:0][NSRC-1:0] srcEvent,
  input wire logic [NPORTS-1:0]           pinIn,
  input wire logic [NPORTS-1:0]           pinOut,
  input wire logic [NPORTS-1:0]           pinOe,
  input wire logic [NPORTS-1:0]           powerDown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] a;
  assign a = regReq.addr;
  a_pin_low: assert property (pinOut == '0) else $error("pin output not low");
  a_rd_pulse: assert property (1 |=> rdValid == $past(regReq.rd)) else $error("bad rdValid");
  a_idle_zero: assert property (!rdValid |-> rdData == '0) else $error("rdData not idle");
  a_unmapped_zero: assert property (regReq.rd && !(a inside {5'h00, 5'h11, 5'h12})
    |=> rdData == '0) else $error("unmapped read nonzero");
  for (genvar p = 0; p < NPORTS; p++) begin : g_p
    logic [1:0]      ctl;
    logic [NSRC-1:0] msk;
    logic            bpd;
    logic            sel;
    logic [NSRC-1:0] ev;
    assign sel = regReq.port == 1'(p);
    assign ev  = srcEvent[p] & msk;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ctl <= '0;
        msk <= '0;
        bpd <= 1'b0;
      end else if (regReq.wr && sel) begin
        if (a == 5'h11) ctl <= regReq.wdata[1:0];
        if (a == 5'h12) msk <= regReq.wdata[NSRC-1:0];
        if (a == 5'h00) bpd <= regReq.wdata[11];
      end
    end
    a_oe_cause: assert property (pinOe[p] |-> ctl == 2'b11) else $error("pin driven");
    a_oe_async: assert property (ctl == 2'b11 && |ev |-> pinOe[p]) else $error("no irq");
    a_clr_release: assert property (regReq.rd && sel && a == 5'h12 && !(|ev) ##1 !(|ev)
      |-> !pinOe[p]) else $error("irq not released");
    a_pd_exact: assert property (1 |=> powerDown[p] == $past(bpd | (!ctl[0] & !pinIn[p])))
      else $error("powerDown wrong");
    a_ctl_readback: assert property (regReq.rd && sel && a == 5'h11
      |=> rdData == {14'h0000, $past(ctl)}) else $error("control readback");
    a_mask_readback: assert property (regReq.rd && sel && a == 5'h12
      |=> rdData[7:0] == $past(msk)) else $error("mask readback");
  end
  c_irq: cover property (pinOe[0] ##1 !pinOe[0]);
  c_strap: cover property (powerDown[1] && rdValid);
  c_ev_read: cover property (regReq.rd && |srcEvent);
endmodule
`default_nettype wire

//--- testbench/ppi_pad_model.sv
// Purpose: Pads and external parties of both shared pins
// Assumes: Open-drain drive, weak pull-up
// Notes:   extLow models a pull-down strap or driver
`timescale 1ns/1ps
`default_nettype none
module ppi_pad_model (
  input  wire logic [1:0] pinOe,
  input  wire logic [1:0] pinOut,
  input  wire logic [1:0] extLow,
  output logic      [1:0] pinIn
);
  assign pinIn = (pinOe & pinOut) | (~pinOe & ~extLow);
endmodule
`default_nettype wire

//--- testbench/tb_port_powerdown_irq_pin_logic.sv
// Purpose: Self-checking bench for ppi_irq_ctrl
// Assumes: Inputs change at the falling edge
// Notes:   Reads queue their expected word
`timescale 1ns/1ps
`default_nettype none
module tb_port_powerdown_irq_pin_logic;
  localparam logic [4:0] BC = 5'h00, CT = 5'h11, ST = 5'h12;
  logic clk = 0, rst_n = 0;
  ppi_pkg::ppi_req_t req = '0;
  logic [1:0][7:0] ev = '0;
  logic [1:0] ext = 2'b10, pin, pOut, pOe, pd;
  logic [15:0] rdData, r;
  logic rdValid;
  logic [15:0] expq[$];
  int miscompares = 0, checks = 0, cyc = 0;
  always #2.5 clk = ~clk;
  ppi_irq_ctrl dut_u (.clk(clk), .rst_n(rst_n), .regReq(req), .rdData(rdData),
    .rdValid(rdValid), .srcEvent(ev), .pinIn(pin), .pinOut(pOut), .pinOe(pOe), .powerDown(pd));
  ppi_pad_model pad_u (.pinOe(pOe), .pinOut(pOut), .extLow(ext), .pinIn(pin));
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    if (expq.size() != 0) miscompares++;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic acc(logic w, logic p, logic [4:0] a, logic [15:0] d, logic [15:0] e = 0,
                     logic [7:0] evt = 0);
    @(negedge clk);
    req = '{port: p, addr: a, wdata: d, wr: w, rd: !w};
    ev[p] = evt;
    if (!w) expq.push_back(e);
    @(negedge clk);
    req = '0;
    ev = '0;
  endtask
  always @(negedge clk) if (rdValid === 1'b1) chk("rdData", rdData, expq.size() ? expq.pop_front() : 'x);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(32'hb8f7));
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1;
    @(negedge clk);
    chk("pd", pd, 2'b10);
    chk("pOe", pOe, 0);
    for (int p = 0; p < 2; p++) begin
      acc(0, p[0], CT, 0);
      acc(0, p[0], ST, 0);
    end
    acc(0, 0, 5'h05, 0);
    $display("reset test done");
    ext = 0;
    acc(1, 0, BC, 16'hffff);
    @(negedge clk);
    chk("pd", pd, 2'b01);
    acc(0, 0, BC, 0, 16'h0800);
    acc(1, 0, BC, 0);
    ext = 2'b10;
    repeat (2) @(negedge clk);
    chk("pd", pd, 2'b10);
    acc(1, 1, CT, 16'h0001);
    @(negedge clk);
    chk("pd", pd, 0);
    acc(1, 1, ST, 16'h0060, 0, 8'h20);
    acc(0, 1, CT, 0, 16'h0001, 8'h20);
    chk("pOe", pOe, 0);
    acc(0, 1, ST, 0, 16'h2060);
    $display("power-down test done");
    acc(1, 0, CT, 16'h0003);
    acc(1, 0, ST, 16'h0060);
    repeat (6) begin
      r = 16'($urandom());
      @(negedge clk) ev[0] = r[7:0];
      #1 chk("pOe", pOe, {15'h0, |(r[7:0] & 8'h60)});
      @(negedge clk) ev = 0;
      chk("pOe", pOe, {15'h0, |(r[7:0] & 8'h60)});
      acc(0, 0, ST, 0, {r[7:0] & 8'h60, 8'h60});
      acc(0, 1, ST, 0, 16'h0060);
      chk("pOe", pOe, 0);
    end
    @(negedge clk) ev[0] = 8'h40;
    acc(0, 0, ST, 0, 16'h4060, 8'h20);
    chk("pOe", pOe, 2'b01);
    acc(0, 0, ST, 0, 16'h2060);
    chk("pOe", pOe, 0);
    acc(1, 0, CT, 16'h0002);
    @(negedge clk) ev[0] = 8'h20;
    #1 chk("pOe", pOe, 0);
    @(negedge clk) ev = 0;
    chk("pd", pd, 0);
    acc(0, 0, ST, 0, 16'h2060);
    $display("interrupt test done");
    repeat (2) @(negedge clk);
    print_verdict;
  end
endmodule
bind ppi_irq_ctrl ppi_irq_ctrl_sva #(.NPORTS(NPORTS), .NSRC(NSRC)) chk_u (.clk(clk),
  .rst_n(rst_n), .regReq(regReq), .rdData(rdData), .rdValid(rdValid), .srcEvent(srcEvent),
  .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .powerDown(powerDown));
`default_nettype wire
